// >>> design/core_state_pkg.sv
// Operation
// [RL1] Flag bit 7 gates every interrupt
// [RL2] Taking interrupt clears enable; return sets it
// [RL3] Set and clear enable by instruction
// [RL4] Bit 6 stores and loads register bits
// [RL5] Bit 5 records low nibble carry
// [RL6] Bit 4 equals negative xor overflow
// [RL7] Bit 3 holds two's complement overflow
// [RL8] Bit 2 flags negative result
// [RL9] Bit 1 flags zero result
// [RL10] Bit 0 flags carry out
// [RL11] No automatic flag save or restore
// [RL12] Four read and write port patterns
// [RL13] Registers mapped at data 0x00 to 0x1F
// [RL14] Top six registers form three pointers
// [RL15] Pointers support displacement, increment, decrement
// [RL16] Byte push decrements, pop increments by one
// [RL17] Calls decrement by two, returns increment
// [RL18] Stack pointer resets to last SRAM address
// [RL19] Stack pointer bytes at I/O 0x3D, 0x3E
// [RL20] Software sets stack before calls, interrupts
// [RL21] One instruction per undivided clock
// [RL22] Read, compute, write back in one cycle
// [RL23] Interrupt return takes four cycles
// [RL24] I/O registers at data 0x20 to 0x5F
package core_state_pkg;
   localparam int unsigned NUM_REGS   = 32;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned REG_IDX_W  = 5;
   // Flag bit positions
   localparam int unsigned FLAG_IE    = 7;
   localparam int unsigned FLAG_COPY  = 6;
   localparam int unsigned FLAG_HALF  = 5;
   localparam int unsigned FLAG_SIGN  = 4;
   localparam int unsigned FLAG_OVF   = 3;
   localparam int unsigned FLAG_NEG   = 2;
   localparam int unsigned FLAG_ZERO  = 1;
   localparam int unsigned FLAG_CARRY = 0;
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   // Data space map
   localparam logic [15:0] REG_SPACE_LAST = 16'h001F;
   localparam logic [15:0] IO_SPACE_FIRST = 16'h0020;
   localparam logic [15:0] IO_SPACE_LAST  = 16'h005F;
   localparam logic [5:0]  IO_SP_LOW      = 6'h3D;
   localparam logic [5:0]  IO_SP_HIGH     = 6'h3E;
   localparam logic [5:0]  IO_FLAGS       = 6'h3F;
   // Pointer pair base indices
   localparam logic [4:0]  PTR_X_LOW = 5'h1A;
   localparam logic [4:0]  PTR_Y_LOW = 5'h1C;
   localparam logic [4:0]  PTR_Z_LOW = 5'h1E;
   localparam logic [15:0] SRAM_LAST_ADDRESS = 16'h04FF;
   localparam int unsigned RETURN_FROM_IRQ_OP_CYCLES = 4;
   // Stack operations
   typedef enum logic [2:0] {
      STK_NONE, STK_PUSH1, STK_POP1, STK_PUSH2, STK_POP2
   } stack_op_t;
   // Pointer addressing forms
   typedef enum logic [1:0] {
      PTR_DISP, PTR_POSTINC, PTR_PREDEC
   } ptr_mode_t;
   // Global enable control
   typedef enum logic [2:0] {
      IE_NONE, IE_SET, IE_CLEAR, IE_TAKE, IE_RETURN
   } ie_op_t;
endpackage

// >>> design/general_reg_array.sv
`timescale 1ns/1ps
module general_reg_array #(
   parameter int unsigned NREG = 32
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic [4:0]   rdAddrA,
   input  wire logic [4:0]   rdAddrB,
   output logic      [7:0]   rdDataA,
   output logic      [7:0]   rdDataB,
   output logic      [15:0]  rdWordA,
   input  wire logic         wrByteEn,
   input  wire logic         wrWordEn,
   input  wire logic [4:0]   wrAddr,
   input  wire logic [15:0]  wrData,
   input  wire logic         ptrWrEn,
   input  wire logic [4:0]   ptrAddr,
   input  wire logic [15:0]  ptrData
);
   logic [7:0] regs_q [NREG];
   wire  [4:0] rdAddrA1 = rdAddrA | 5'h01;
   wire  [4:0] wrAddrHi = wrAddr | 5'h01;
   wire  [4:0] ptrAddrHi = ptrAddr | 5'h01;

   // Combinational reads, same cycle operand fetch
   assign rdDataA = regs_q[rdAddrA];                           // [RL12]
   assign rdDataB = regs_q[rdAddrB];                           // [RL22]
   assign rdWordA = {regs_q[rdAddrA1], regs_q[rdAddrA & 5'h1E]};

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NREG; i++) regs_q[i] <= 8'h00;
      end else begin
         if (ptrWrEn) begin                                   // [RL15]
            regs_q[ptrAddr & 5'h1E] <= ptrData[7:0];
            regs_q[ptrAddrHi]        <= ptrData[15:8];
         end
         if (wrWordEn) begin                                  // [RL12]
            regs_q[wrAddr & 5'h1E] <= wrData[7:0];
            regs_q[wrAddrHi]       <= wrData[15:8];
         end else if (wrByteEn) begin
            regs_q[wrAddr] <= wrData[7:0];
         end
      end
   end
endmodule

// >>> design/cpu_status_regfile_stack.sv
`timescale 1ns/1ps
module cpu_status_regfile_stack
   import core_state_pkg::*;
#(
   parameter logic [15:0] SRAM_LAST = core_state_pkg::SRAM_LAST_ADDRESS
) (
   input  wire logic                        clock,
   input  wire logic                        nrst,
   // Register file ports from decoder and ALU
   input  wire logic [4:0]                  rdAddrA,
   input  wire logic [4:0]                  rdAddrB,
   output logic      [7:0]                  rdDataA,
   output logic      [7:0]                  rdDataB,
   output logic      [15:0]                 rdWordA,
   input  wire logic                        wrByteEn,
   input  wire logic                        wrWordEn,
   input  wire logic [4:0]                  wrAddr,
   input  wire logic [15:0]                 wrData,
   // ALU flag update
   input  wire logic [7:0]                  flagUpdMask,
   input  wire logic                        aluHalf,
   input  wire logic                        aluOvf,
   input  wire logic                        aluNeg,
   input  wire logic                        aluZero,
   input  wire logic                        aluCarry,
   // Bit copy
   input  wire logic                        storeBitToCopy,
   input  wire logic                        loadBitFromCopy,
   input  wire logic [4:0]                  bitReg,
   input  wire logic [2:0]                  bitSel,
   // Global enable and interrupt
   input  wire core_state_pkg::ie_op_t      ieOp,
   input  wire logic                        irqPending,
   output logic                             irqTake,
   output logic                             retiBusy,
   // Stack
   input  wire core_state_pkg::stack_op_t   stackOp,
   output logic      [15:0]                 stackPtr,
   // Pointer addressing
   input  wire logic                        ptrEn,
   input  wire logic [1:0]                  ptrSel,
   input  wire core_state_pkg::ptr_mode_t   ptrMode,
   input  wire logic [5:0]                  ptrDisp,
   output logic      [15:0]                 ptrAddrOut,
   // Data space access
   input  wire logic                        dsRead,
   input  wire logic                        dsWrite,
   input  wire logic [15:0]                 dsAddr,
   input  wire logic [7:0]                  dsWrData,
   output logic      [7:0]                  dsRdData,
   output logic                             dsHit,
   output logic      [7:0]                  coreFlags
);
   import core_state_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0]  flags_q, flags_d;
   logic [15:0] sp_q, sp_d;
   logic [1:0]  retiCnt_q, retiCnt_d;
   logic        retiBusy_q;
   logic        irqTake_q;
   logic [15:0] ptrAddr_q;
   logic [7:0]  dsRd_q;
   logic        dsHit_q;

   // ---------------------------------------------------------------
   // Data space decode
   // ---------------------------------------------------------------
   wire        dsInRegs = dsAddr <= REG_SPACE_LAST;                // [RL13]
   wire        dsInIo   = (dsAddr >= IO_SPACE_FIRST) &&
                          (dsAddr <= IO_SPACE_LAST);               // [RL24]
   wire [5:0]  ioIdx    = 6'(dsAddr - IO_SPACE_FIRST);
   wire        ioSpLo   = dsInIo && ioIdx == IO_SP_LOW;            // [RL19]
   wire        ioSpHi   = dsInIo && ioIdx == IO_SP_HIGH;           // [RL19]
   wire        ioFlags  = dsInIo && ioIdx == IO_FLAGS;
   wire        dsMapped = dsInRegs || ioSpLo || ioSpHi || ioFlags;

   // ---------------------------------------------------------------
   // Pointer pair select and addressing
   // ---------------------------------------------------------------
   wire [4:0]  ptrBase = (ptrSel == 2'd0) ? PTR_X_LOW :
                         (ptrSel == 2'd1) ? PTR_Y_LOW : PTR_Z_LOW; // [RL14]
   wire [15:0] ptrWord;
   wire [15:0] ptrInc  = ptrWord + 16'h0001;
   wire [15:0] ptrDec  = ptrWord - 16'h0001;
   wire [15:0] ptrPlus = ptrWord + {10'h000, ptrDisp};
   wire [15:0] ptrEff  = (ptrMode == PTR_DISP)   ? ptrPlus :
                         (ptrMode == PTR_PREDEC) ? ptrDec : ptrWord; // [RL15]
   wire        ptrUpd  = ptrEn && ptrMode != PTR_DISP;
   wire [15:0] ptrNew  = (ptrMode == PTR_PREDEC) ? ptrDec : ptrInc;

   // Read port A is lent to the pointer fetch when addressing
   wire [4:0]  portA   = ptrEn ? ptrBase :
                         (loadBitFromCopy || storeBitToCopy) ? bitReg :
                         dsInRegs && dsRead ? dsAddr[4:0] : rdAddrA;
   wire [7:0]  regA;
   wire [7:0]  regB;

   // ---------------------------------------------------------------
   // Writes into the array
   // ---------------------------------------------------------------
   wire [7:0]  bitMask   = 8'h01 << bitSel;
   wire [7:0]  bldByte   = flags_q[FLAG_COPY] ? (regA | bitMask)
                                              : (regA & ~bitMask); // [RL4]
   wire        dsRegWr   = dsWrite && dsInRegs;                    // [RL13]
   wire        byteWr    = wrByteEn || loadBitFromCopy || dsRegWr;
   wire [4:0]  wrIdx     = loadBitFromCopy ? bitReg :
                           dsRegWr ? dsAddr[4:0] : wrAddr;
   wire [15:0] wrVal     = loadBitFromCopy ? {8'h00, bldByte} :
                           dsRegWr ? {8'h00, dsWrData} : wrData;

   general_reg_array #(.NREG(NUM_REGS)) u_regs (
      .clock   (clock),
      .nrst    (nrst),
      .rdAddrA (portA),
      .rdAddrB (rdAddrB),
      .rdDataA (regA),
      .rdDataB (regB),
      .rdWordA (ptrWord),
      .wrByteEn(byteWr && !wrWordEn),
      .wrWordEn(wrWordEn),
      .wrAddr  (wrIdx),
      .wrData  (wrVal),
      .ptrWrEn (ptrUpd),
      .ptrAddr (ptrBase),
      .ptrData (ptrNew)
   );

   // Operand reads pass straight through for single cycle ALU work
   assign rdDataA = regA;                                          // [RL22]
   assign rdDataB = regB;                                          // [RL12]
   assign rdWordA = ptrWord;

   // ---------------------------------------------------------------
   // Flags
   // ---------------------------------------------------------------
   wire irqGo = irqPending && flags_q[FLAG_IE] && !retiBusy_q &&
                ieOp != IE_CLEAR;                                  // [RL1]
   wire retiStart = ieOp == IE_RETURN && !retiBusy_q;

   always_comb begin
      flags_d = flags_q;
      if (ioFlags && dsWrite) flags_d = dsWrData;
      if (flagUpdMask[FLAG_HALF])  flags_d[FLAG_HALF]  = aluHalf;  // [RL5]
      if (flagUpdMask[FLAG_OVF])   flags_d[FLAG_OVF]   = aluOvf;   // [RL7]
      if (flagUpdMask[FLAG_NEG])   flags_d[FLAG_NEG]   = aluNeg;   // [RL8]
      if (flagUpdMask[FLAG_ZERO])  flags_d[FLAG_ZERO]  = aluZero;  // [RL9]
      if (flagUpdMask[FLAG_CARRY]) flags_d[FLAG_CARRY] = aluCarry; // [RL10]
      if (flagUpdMask[FLAG_OVF] || flagUpdMask[FLAG_NEG] ||
          flagUpdMask[FLAG_SIGN])
         flags_d[FLAG_SIGN] = flags_d[FLAG_NEG] ^ flags_d[FLAG_OVF]; // [RL6]
      if (storeBitToCopy)
         flags_d[FLAG_COPY] = regA[bitSel];                        // [RL4]
      case (ieOp)
         IE_SET:   flags_d[FLAG_IE] = 1'b1;                        // [RL3]
         IE_CLEAR: flags_d[FLAG_IE] = 1'b0;                        // [RL3]
         default:  ;
      endcase
      // Entry and return touch only the enable bit, never the rest
      if (irqGo) flags_d[FLAG_IE] = 1'b0;               // [RL2][RL11]
      if (retiBusy_q && retiCnt_q == 2'(RETURN_FROM_IRQ_OP_CYCLES - 1))
         flags_d[FLAG_IE] = 1'b1;                        // [RL2][RL23]
   end

   // ---------------------------------------------------------------
   // Stack pointer
   // ---------------------------------------------------------------
   always_comb begin
      sp_d = sp_q;
      if (ioSpLo && dsWrite) sp_d[7:0]  = dsWrData;                // [RL19]
      if (ioSpHi && dsWrite) sp_d[15:8] = dsWrData;                // [RL19]
      case (stackOp)
         STK_PUSH1: sp_d = sp_q - 16'h0001;                        // [RL16]
         STK_POP1:  sp_d = sp_q + 16'h0001;                        // [RL16]
         STK_PUSH2: sp_d = sp_q - 16'h0002;                        // [RL17]
         STK_POP2:  sp_d = sp_q + 16'h0002;                        // [RL17]
         default:   ;
      endcase
      if (irqGo) sp_d = sp_q - 16'h0002;                           // [RL17]
      if (retiStart) sp_d = sp_q + 16'h0002;                       // [RL23]
   end

   // ---------------------------------------------------------------
   // Interrupt return sequencing
   // ---------------------------------------------------------------
   always_comb begin
      retiCnt_d = retiCnt_q;
      if (retiStart) retiCnt_d = 2'd0;
      else if (retiBusy_q) retiCnt_d = 2'(retiCnt_q + 2'd1);
   end

   wire retiBusyNext = retiStart ||
                       (retiBusy_q && retiCnt_q != 2'(RETURN_FROM_IRQ_OP_CYCLES - 1));

   // ---------------------------------------------------------------
   // Data space read mux
   // ---------------------------------------------------------------
   wire [7:0] dsRdNext = dsInRegs ? regA :
                         ioSpLo   ? sp_q[7:0] :
                         ioSpHi   ? sp_q[15:8] :
                         ioFlags  ? flags_q : 8'h00;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin // [RL21]
      if (!nrst) begin
         flags_q    <= FLAGS_RESET;
         sp_q       <= SRAM_LAST;                                  // [RL18]
         retiCnt_q  <= 2'd0;
         retiBusy_q <= 1'b0;
      end else begin
         flags_q    <= flags_d;
         sp_q       <= sp_d;
         retiCnt_q  <= retiCnt_d;
         retiBusy_q <= retiBusyNext;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irqTake_q <= 1'b0;
         ptrAddr_q <= 16'h0000;
         dsRd_q    <= 8'h00;
         dsHit_q   <= 1'b0;
      end else begin
         irqTake_q <= irqGo;                                       // [RL1]
         ptrAddr_q <= ptrEff;                                      // [RL15]
         dsRd_q    <= dsRead ? dsRdNext : 8'h00;
         dsHit_q   <= (dsRead || dsWrite) && dsMapped;
      end
   end

   assign irqTake    = irqTake_q;
   assign retiBusy   = retiBusy_q;
   assign stackPtr   = sp_q;
   assign ptrAddrOut = ptrAddr_q;
   assign dsRdData   = dsRd_q;
   assign dsHit      = dsHit_q;
   assign coreFlags  = flags_q;
endmodule

// >>> verification/irq_source_model.sv
`timescale 1ns/1ps
module irq_source_model (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic raise,
   input  wire logic irqTake,
   output logic      irqPending
);
   // Level request held until the core accepts it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irqPending <= 1'b0;
      end else if (raise) begin
         irqPending <= 1'b1;
      end else if (irqTake) begin
         irqPending <= 1'b0;
      end
   end
endmodule

// >>> verification/cpu_status_regfile_stack_sva.sv
`timescale 1ns/1ps
module cpu_status_regfile_stack_sva
   import core_state_pkg::*;
#(
   parameter logic [15:0] SRAM_LAST = core_state_pkg::SRAM_LAST_ADDRESS
) (
   input wire logic                      clock,
   input wire logic                      nrst,
   input wire logic [15:0]               rdWordA,
   input wire logic [7:0]                flagUpdMask,
   input wire logic                      aluOvf,
   input wire logic                      aluNeg,
   input wire core_state_pkg::ie_op_t    ieOp,
   input wire logic                      irqPending,
   input wire logic                      irqTake,
   input wire logic                      retiBusy,
   input wire core_state_pkg::stack_op_t stackOp,
   input wire logic [15:0]               stackPtr,
   input wire logic                      ptrEn,
   input wire core_state_pkg::ptr_mode_t ptrMode,
   input wire logic [5:0]                ptrDisp,
   input wire logic [15:0]               ptrAddrOut,
   input wire logic                      dsRead,
   input wire logic                      dsWrite,
   input wire logic [15:0]               dsAddr,
   input wire logic [7:0]                dsRdData,
   input wire logic [7:0]                coreFlags
);
   logic       quiet;
   logic [7:0] spLow;
   // No interrupt, return or data write competing for the pointer
   assign quiet = ieOp == IE_NONE && !retiBusy && !irqPending && !dsWrite;
   assign spLow = stackPtr[7:0];
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence s_retStart;
      ieOp == IE_RETURN && !retiBusy;
   endsequence
   sequence s_busy4;
      retiBusy [*4] ##1 (!retiBusy && coreFlags[7]);
   endsequence
   property p_return_from_irq_op;
      s_retStart |=> s_busy4;
   endproperty
   a_return_from_irq_op: assert property (p_return_from_irq_op) else $error("return timing");
   property p_gate;
      !coreFlags[7] |=> !irqTake;
   endproperty
   a_gate: assert property (p_gate) else $error("gated irq taken");
   property p_take;
      irqTake |-> !coreFlags[7] && stackPtr == $past(stackPtr) - 16'h0002;
   endproperty
   a_take: assert property (p_take) else $error("irq entry");
   property p_stack;
      stackOp == STK_PUSH1 && quiet |=> stackPtr == $past(stackPtr) - 16'h0001;
   endproperty
   a_stack: assert property (p_stack) else $error("push step");
   property p_sign;
      flagUpdMask[4:2] == 3'h7 |=>
         coreFlags[4] == ($past(aluNeg) ^ $past(aluOvf));
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag");
   property p_ptr;
      ptrEn && ptrMode == PTR_DISP |=>
         ptrAddrOut == $past(rdWordA) + {10'h000, $past(ptrDisp)};
   endproperty
   a_ptr: assert property (p_ptr) else $error("displacement");
   property p_dsSp;
      dsRead && dsAddr == 16'h005D && stackOp == STK_NONE && quiet |=>
         dsRdData == $past(spLow);
   endproperty
   a_dsSp: assert property (p_dsSp) else $error("sp low read");
   property p_reset;
      $rose(nrst) |-> stackPtr == SRAM_LAST && coreFlags == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
endmodule

bind cpu_status_regfile_stack cpu_status_regfile_stack_sva #(
   .SRAM_LAST(SRAM_LAST)
) u_sva (
   .clock, .nrst, .rdWordA, .flagUpdMask, .aluOvf, .aluNeg, .ieOp,
   .irqPending, .irqTake, .retiBusy, .stackOp, .stackPtr, .ptrEn,
   .ptrMode, .ptrDisp, .ptrAddrOut, .dsRead, .dsWrite, .dsAddr,
   .dsRdData, .coreFlags
);

// >>> verification/cpu_status_regfile_stack_tb_top.sv
`timescale 1ns/1ps
module cpu_status_regfile_stack_tb_top;
   import core_state_pkg::*;
   logic        clock, nrst, raise, wrByteEn, wrWordEn, ptrEn, dsRead;
   logic        aluHalf, aluOvf, aluNeg, aluZero, aluCarry, irqPending;
   logic        storeBitToCopy, loadBitFromCopy, irqTake, retiBusy;
   logic        dsWrite, dsHit;
   logic [4:0]  rdAddrA, rdAddrB, wrAddr, bitReg;
   logic [15:0] wrData, dsAddr, rdWordA, stackPtr, ptrAddrOut;
   logic [7:0]  flagUpdMask, dsWrData, rdDataA, rdDataB, dsRdData, coreFlags;
   logic [2:0]  bitSel;
   logic [1:0]  ptrSel;
   logic [5:0]  ptrDisp;
   ie_op_t      ieOp;
   stack_op_t   stackOp;
   ptr_mode_t   ptrMode;
   int          bad_count, cmp_count, i;
   stack_op_t   ops[4] = '{STK_PUSH2, STK_POP1, STK_PUSH1, STK_POP2};
   logic [15:0] spExp[4] = '{16'h03FE, 16'h03FF, 16'h03FE, 16'h0400};
   cpu_status_regfile_stack u_dut (
      .clock, .nrst, .rdAddrA, .rdAddrB, .rdDataA, .rdDataB, .rdWordA,
      .wrByteEn, .wrWordEn, .wrAddr, .wrData, .flagUpdMask, .aluHalf,
      .aluOvf, .aluNeg, .aluZero, .aluCarry, .storeBitToCopy,
      .loadBitFromCopy, .bitReg, .bitSel, .ieOp, .irqPending, .irqTake,
      .retiBusy, .stackOp, .stackPtr, .ptrEn, .ptrSel, .ptrMode, .ptrDisp,
      .ptrAddrOut, .dsRead, .dsWrite, .dsAddr, .dsWrData, .dsRdData,
      .dsHit, .coreFlags
   );
   irq_source_model u_irq (.clock, .nrst, .raise, .irqTake, .irqPending);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #20000;
      bad_count++;
      final_report();
   end
   task automatic tick();
      @(posedge clock);
      #1;
   endtask
   task automatic chk16(input string n, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk8(input string n, input logic [7:0] e, g);
      chk16(n, {8'h00, e}, {8'h00, g});
   endtask
   // Drops every request; one edge passes so nothing is driven twice
   task automatic idle();
      {raise, wrByteEn, wrWordEn, ptrEn, dsRead, dsWrite} = '0;
      {storeBitToCopy, loadBitFromCopy, flagUpdMask} = '0;
      ieOp = IE_NONE;
      stackOp = STK_NONE;
      tick();
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic w);
      wrAddr = a;
      wrData = d;
      wrByteEn = !w;
      wrWordEn = w;
      tick();
      idle();
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
      dsAddr = a;
      dsRead = 1'b1;
      tick();
      chk8("dsData", e, dsRdData);
      chk8("dsHit", {7'h00, h}, {7'h00, dsHit});
      idle();
   endtask
   task automatic ptr(input ptr_mode_t m, input logic [15:0] eo, ep);
      ptrEn = 1'b1;
      ptrMode = m;
      tick();
      chk16("ptrOut", eo, ptrAddrOut);
      idle();
      chk16("ptrReg", ep, rdWordA);
   endtask
   task automatic flg(input logic [4:0] hvnzc, input logic [7:0] e);
      flagUpdMask = 8'h3F;
      {aluHalf, aluOvf, aluNeg, aluZero, aluCarry} = hvnzc;
      tick();
      idle();
      chk8("flags", e, coreFlags);
   endtask
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      {raise, wrByteEn, wrWordEn, ptrEn, dsRead, dsWrite, aluHalf, aluOvf,
       aluNeg, aluZero, aluCarry, storeBitToCopy, loadBitFromCopy} = '0;
      {rdAddrA, rdAddrB, wrAddr, bitReg, bitSel, ptrSel, ptrDisp} = '0;
      {wrData, dsAddr, flagUpdMask, dsWrData} = '0;
      ieOp = IE_NONE;
      stackOp = STK_NONE;
      ptrMode = PTR_DISP;
      repeat (16) @(posedge clock);
      #1;
      nrst = 1'b1;
      chk16("sp", 16'h04FF, stackPtr);
      rd(16'h005D, 8'hFF, 1'b1);
      rd(16'h005E, 8'h04, 1'b1);
      rd(16'h0040, 8'h00, 1'b0);
      for (i = 0; i < 32; i++) wr(5'(i), 16'(i ^ 8'hA5), 1'b0);
      for (i = 0; i < 32; i++) begin
         rdAddrA = 5'(i);
         rdAddrB = 5'(31 - i);
         tick();
         chk8("rdA", 8'(i ^ 8'hA5), rdDataA);
         chk8("rdB", 8'((31 - i) ^ 8'hA5), rdDataB);
         rd(16'(i), 8'(i ^ 8'hA5), 1'b1);
      end
      ptrDisp = 6'h3F;
      for (i = 0; i < 3; i++) begin
         wr(5'(27 + 2 * i), 16'(16'h0200 + i), 1'b1);
         ptrSel = 2'(i);
         rdAddrA = 5'(26 + 2 * i);
         ptr(PTR_DISP, 16'(16'h023F + i), 16'(16'h0200 + i));
      end
      ptr(PTR_POSTINC, 16'h0202, 16'h0203);
      ptr(PTR_PREDEC, 16'h0202, 16'h0202);
      flg(5'b10111, 8'h37);
      flg(5'b01100, 8'h0C);
      flg(5'b01001, 8'h19);
      storeBitToCopy = 1'b1;
      bitReg = 5'h03;
      bitSel = 3'h7;
      tick();
      idle();
      chk8("flags", 8'h59, coreFlags);
      loadBitFromCopy = 1'b1;
      bitReg = 5'h05;
      bitSel = 3'h3;
      tick();
      idle();
      rdAddrA = 5'h05;
      tick();
      chk8("rdA", 8'hA8, rdDataA);
      dsAddr = 16'h005D;
      dsWrite = 1'b1;
      tick();
      idle();
      chk16("sp", 16'h0400, stackPtr);
      for (i = 0; i < 4; i++) begin
         stackOp = ops[i];
         tick();
         idle();
         chk16("sp", spExp[i], stackPtr);
      end
      ieOp = IE_SET;
      tick();
      idle();
      chk8("flags", 8'hD9, coreFlags);
      // Request pending at the very edge that clears the enable
      raise = 1'b1;
      tick();
      ieOp = IE_CLEAR;
      raise = 1'b0;
      tick();
      idle();
      chk8("flags", 8'h59, coreFlags);
      for (i = 0; i < 4; i++) begin
         chk8("take", 8'h00, {7'h00, irqTake});
         tick();
      end
      ieOp = IE_SET;
      tick();
      idle();
      chk8("take", 8'h01, {7'h00, irqTake});
      chk8("flags", 8'h59, coreFlags);
      chk16("sp", 16'h03FE, stackPtr);
      ieOp = IE_RETURN;
      tick();
      chk16("sp", 16'h0400, stackPtr);
      idle();
      for (i = 0; i < 3; i++) begin
         chk8("busy", 8'h01, {7'h00, retiBusy});
         chk8("flags", 8'h59, coreFlags);
         tick();
      end
      chk8("busy", 8'h00, {7'h00, retiBusy});
      chk8("flags", 8'hD9, coreFlags);
      rd(16'h005F, 8'hD9, 1'b1);
      final_report();
   end
endmodule
